// ### design/pwr_cfg.svh
// offsets, field positions, reset values and counts of the power-mode controller
`ifndef PWR_CFG_SVH
`define PWR_CFG_SVH
// ************************************************************
// register byte addresses
// ************************************************************
`define OFF_MODE 8'h00
`define OFF_WDOG 8'h04
`define OFF_STAT 8'h08
`define OFF_WAKE 8'h0C
`define OFF_MISC 8'h10
// ************************************************************
// reset values
// ************************************************************
`define MODE_RST 8'h01
`define WDOG_RST 8'h7A
`define WAKE_RST 8'h00
// ************************************************************
// field positions
// ************************************************************
`define MODE_HL 0
`define MODE_IDLE 1
`define MODE_READY 2
`define MODE_FAST 3
`define MODE_CKS_HI 7
`define MODE_CKS_LO 5
`define WDOG_PERI 7
`define WDOG_WS_HI 6
`define WDOG_WS_LO 4
`define WDOG_EN_HI 3
`define WDOG_EN_LO 0
`define MISC_LVD 0
// ************************************************************
// codes and counts
// ************************************************************
`define WDOG_OFF_CODE 4'hA
`define CKS_FAST_MIN 3'h2
`define XTAL_CYCLES 11'h400
`define RC_CYCLES 11'h010
`define WDT_BASE 16'h0100
`endif

// ### design/pwr_pkg.sv
// types of the power-mode controller
package pwr_pkg;
    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_DEEP = 5'h02,
        ST_SLEEP2 = 5'h04,
        ST_SECOND_IDLE_STATE = 5'h08,
        ST_IDLE2 = 5'h10
    } pwr_state_t;
    typedef struct packed {
        logic sys;
        logic tbase;
        logic wdog;
        logic sub;
    } clk_gate_t;
    typedef struct packed {
        logic full_rst;
        logic wdog_rst;
        logic irq_svc;
        logic resume;
    } wake_evt_t;
endpackage : pwr_pkg

// ### design/halt_power_mode_wakeup_ctrl.sv
// halt, low-power state, wake-up and watchdog controller with APB registers
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pwr_cfg.svh"
module halt_power_mode_wakeup_ctrl #(
    parameter int N_PA = 8,
    parameter int N_IRQ = 4,
    parameter bit WDT_SRC_SYS = 1'b0,
    parameter bit WDT_CFG_EN = 1'b0,
    parameter bit OSC_XTAL = 1'b1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core side
    input wire logic halt_req,
    input wire logic wdt_clr,
    input wire logic [N_IRQ-1:0] irq_req,
    input wire logic [N_IRQ-1:0] irq_en,
    input wire logic stack_full,
    // pins and oscillators
    input wire logic ext_reset_n,
    input wire logic [N_PA-1:0] port_a,
    input wire logic sub_clock,
    input wire logic hs_osc,
    // clock control and events
    output pwr_pkg::clk_gate_t clk_gate,
    output pwr_pkg::wake_evt_t wake_evt,
    output logic cpu_halted,
    output logic use_high_speed,
    output logic run_from_sub,
    output logic high_speed_ready_flag,
    output logic power_down_flag,
    output logic watchdog_timeout_flag
);
    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [N_PA-1:0] pa_s1_q, pa_s2_q, pa_s3_q;
    logic rst_s1_q, rst_s2_q, rst_s3_q;
    logic sub_s1_q, sub_s2_q, sub_s3_q;
    logic hs_s1_q, hs_s2_q, hs_s3_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_s1_q <= '1;
            pa_s2_q <= '1;
            pa_s3_q <= '1;
            rst_s1_q <= 1'b1;
            rst_s2_q <= 1'b1;
            rst_s3_q <= 1'b1;
            sub_s1_q <= 1'b0;
            sub_s2_q <= 1'b0;
            sub_s3_q <= 1'b0;
            hs_s1_q <= 1'b0;
            hs_s2_q <= 1'b0;
            hs_s3_q <= 1'b0;
        end else begin
            pa_s1_q <= port_a;
            pa_s2_q <= pa_s1_q;
            pa_s3_q <= pa_s2_q;
            rst_s1_q <= ext_reset_n;
            rst_s2_q <= rst_s1_q;
            rst_s3_q <= rst_s2_q;
            sub_s1_q <= sub_clock;
            sub_s2_q <= sub_s1_q;
            sub_s3_q <= sub_s2_q;
            hs_s1_q <= hs_osc;
            hs_s2_q <= hs_s1_q;
            hs_s3_q <= hs_s2_q;
        end
    end
    // edges come from the second and third stages, so the first stage never feeds logic
    wire [N_PA-1:0] pa_fall = pa_s3_q & ~pa_s2_q;
    wire ext_fall = rst_s3_q & ~rst_s2_q;
    wire sub_tick = sub_s2_q & ~sub_s3_q;
    wire hs_tick = hs_s2_q & ~hs_s3_q;
    // ************************************************************
    // registers and apb
    // ************************************************************
    logic [7:0] mode_q, wdog_q;
    logic [N_PA-1:0] wake_q;
    logic lvd_q, pready_q, pslverr_q;
    logic [31:0] prdata_q, rd_val;
    logic mapped;
    pwr_pkg::pwr_state_t state_q, state_d;
    logic pdf_q, to_q, ready_q;
    wire access = psel & penable;
    // one wait state keeps prdata a flop output
    wire wr_fire = access & pready_q & pwrite & mapped;
    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (paddr)
            `OFF_MODE: rd_val = {24'h00_0000, mode_q[7:3], ready_q, mode_q[1:0]};
            `OFF_WDOG: rd_val = {24'h00_0000, wdog_q};
            `OFF_STAT: rd_val = {25'h000_0000, state_q, to_q, pdf_q};
            `OFF_WAKE: rd_val = 32'(wake_q);
            `OFF_MISC: rd_val = {31'h0000_0000, lvd_q};
            default: mapped = 1'b0;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= access & ~pready_q;
            if (access & ~pready_q) begin
                prdata_q <= mapped ? rd_val : 32'h0000_0000;
                pslverr_q <= ~mapped;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= `MODE_RST;
            wdog_q <= `WDOG_RST;
            wake_q <= '0;
            lvd_q <= 1'b0;
        end else if (wr_fire) begin
            if (paddr == `OFF_MODE) mode_q <= pwdata[7:0];
            if (paddr == `OFF_WDOG) wdog_q <= pwdata[7:0];
            if (paddr == `OFF_WAKE) wake_q <= pwdata[N_PA-1:0];
            if (paddr == `OFF_MISC) lvd_q <= pwdata[`MISC_LVD];
        end
    end
    // ************************************************************
    // watchdog
    // ************************************************************
    logic [15:0] wdt_cnt_q;
    logic [1:0] div_q;
    wire wdt_on = WDT_CFG_EN | (wdog_q[`WDOG_EN_HI:`WDOG_EN_LO] != `WDOG_OFF_CODE);
    wire [2:0] ws = wdog_q[`WDOG_WS_HI:`WDOG_WS_LO];
    wire [15:0] wdt_limit = 16'(`WDT_BASE << ws) - 16'h0001;
    function automatic logic wdt_runs(input pwr_pkg::pwr_state_t s, input logic on);
        wdt_runs = 1'b0;
        unique case (s)
            pwr_pkg::ST_RUN: wdt_runs = on;
            pwr_pkg::ST_DEEP: wdt_runs = 1'b0;
            pwr_pkg::ST_SLEEP2: wdt_runs = on & ~WDT_SRC_SYS;
            pwr_pkg::ST_SECOND_IDLE_STATE: wdt_runs = on & ~WDT_SRC_SYS;
            pwr_pkg::ST_IDLE2: wdt_runs = on;
        endcase
    endfunction : wdt_runs
    wire sys_run = (state_q == pwr_pkg::ST_RUN) | (state_q == pwr_pkg::ST_IDLE2);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) div_q <= 2'h0;
        else if (sys_run) div_q <= div_q + 2'h1;
    end
    // system clock over four, or the sub-clock edge
    wire src_tick = WDT_SRC_SYS ? (sys_run & (div_q == 2'h3)) : sub_tick;
    wire wdt_tick = src_tick & wdt_runs(state_q, wdt_on);
    wire wdt_ovf = wdt_tick & (wdt_cnt_q == wdt_limit);
    wire halt_go = halt_req & (state_q == pwr_pkg::ST_RUN);
    // a disabled watchdog ignores the clear: every watchdog instruction is then a no-op
    wire wdt_clr_ok = wdt_clr & wdt_on & (state_q == pwr_pkg::ST_RUN);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) wdt_cnt_q <= 16'h0000;
        else if (ext_fall | halt_go | wdt_clr_ok | wdt_ovf) wdt_cnt_q <= 16'h0000;
        else if (wdt_tick) wdt_cnt_q <= wdt_cnt_q + 16'h0001;
    end
    // ************************************************************
    // state machine
    // ************************************************************
    // snapshot at halt: a request already pending cannot wake, only new bits count
    logic [N_IRQ-1:0] irq_snap_q;
    wire [N_IRQ-1:0] irq_new = irq_req & ~irq_snap_q;
    wire pa_wake = |(pa_fall & wake_q);
    wire asleep = (state_q != pwr_pkg::ST_RUN);
    wire wake_any = ext_fall | wdt_ovf | (|irq_new) | pa_wake;
    wire irq_svc = asleep & ~ext_fall & ~wdt_ovf & |(irq_new & irq_en) & ~stack_full;
    always_comb begin
        state_d = state_q;
        if (halt_go) begin
            if (!mode_q[`MODE_IDLE]) begin
                if (wdt_on | lvd_q) state_d = pwr_pkg::ST_SLEEP2;
                else state_d = pwr_pkg::ST_DEEP;
            end else begin
                if (wdog_q[`WDOG_PERI]) state_d = pwr_pkg::ST_IDLE2;
                else state_d = pwr_pkg::ST_SECOND_IDLE_STATE;
            end
        end else if (asleep & wake_any) begin
            state_d = pwr_pkg::ST_RUN;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= pwr_pkg::ST_RUN;
            irq_snap_q <= '0;
        end else begin
            state_q <= state_d;
            if (halt_go) irq_snap_q <= irq_req;
        end
    end
    // ************************************************************
    // status flags
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pdf_q <= 1'b0;
        else if (halt_go) pdf_q <= 1'b1;
        else if (wdt_clr_ok) pdf_q <= 1'b0;
    end
    // an overflow in the halt cycle still wins over the entry clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) to_q <= 1'b0;
        else if (wdt_ovf) to_q <= 1'b1;
        else if (halt_go) to_q <= 1'b0;
    end
    // ************************************************************
    // high-speed oscillator ready and fast wake
    // ************************************************************
    logic [10:0] hs_cnt_q;
    logic run_sub_q;
    wire [10:0] hs_target = OSC_XTAL ? `XTAL_CYCLES : `RC_CYCLES;
    // idle2 keeps the fast oscillator running, so its ready flag survives the halt
    wire osc_stop = halt_go & (state_d != pwr_pkg::ST_IDLE2);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
            hs_cnt_q <= 11'h000;
        end else if (osc_stop) begin
            ready_q <= 1'b0;
            hs_cnt_q <= 11'h000;
        end else if (!ready_q & !asleep & hs_tick) begin
            hs_cnt_q <= hs_cnt_q + 11'h001;
            if (hs_cnt_q == hs_target - 11'h001) ready_q <= 1'b1;
        end
    end
    wire fast_from = (state_q == pwr_pkg::ST_SLEEP2) | (state_q == pwr_pkg::ST_SECOND_IDLE_STATE);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) run_sub_q <= 1'b0;
        else if (asleep & wake_any & fast_from & OSC_XTAL & mode_q[`MODE_FAST]) run_sub_q <= 1'b1;
        else if (ready_q) run_sub_q <= 1'b0;
    end
    // ************************************************************
    // registered outputs
    // ************************************************************
    pwr_pkg::clk_gate_t gate_q;
    pwr_pkg::wake_evt_t evt_q;
    logic halted_q, hs_sel_q;
    // gates follow the next state so they switch on the same edge as the state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_q <= 4'hF;
            halted_q <= 1'b0;
        end else begin
            gate_q.sys <= (state_d == pwr_pkg::ST_RUN) | (state_d == pwr_pkg::ST_IDLE2);
            gate_q.tbase <= (state_d != pwr_pkg::ST_DEEP) & (state_d != pwr_pkg::ST_SLEEP2);
            gate_q.wdog <= wdt_runs(state_d, wdt_on);
            gate_q.sub <= (state_d != pwr_pkg::ST_DEEP);
            halted_q <= (state_d != pwr_pkg::ST_RUN);
        end
    end
    // external and watchdog resets can pulse together; reset sources outrank interrupt service and plain resume
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_q <= 4'h0;
        end else begin
            evt_q.full_rst <= ext_fall;
            evt_q.wdog_rst <= wdt_ovf;
            evt_q.irq_svc <= irq_svc;
            evt_q.resume <= asleep & ~ext_fall & ~wdt_ovf & wake_any & ~irq_svc;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hs_sel_q <= 1'b1;
        else hs_sel_q <= mode_q[`MODE_HL] | (mode_q[`MODE_CKS_HI:`MODE_CKS_LO] >= `CKS_FAST_MIN);
    end
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign clk_gate = gate_q;
    assign wake_evt = evt_q;
    assign cpu_halted = halted_q;
    assign use_high_speed = hs_sel_q;
    assign run_from_sub = run_sub_q;
    assign high_speed_ready_flag = ready_q;
    assign power_down_flag = pdf_q;
    assign watchdog_timeout_flag = to_q;
    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_halt_deep: assert property (halt_go & ~mode_q[1] & ~wdt_on & ~lvd_q |=> state_q == pwr_pkg::ST_DEEP)
        else $error("halt did not reach deep sleep");
    chk_halt_sleep: assert property (halt_go & ~mode_q[1] & (wdt_on | lvd_q) |=> state_q == pwr_pkg::ST_SLEEP2)
        else $error("halt did not reach sleep2");
    chk_halt_idle: assert property (halt_go & mode_q[1] |=> state_q == (wdog_q[7] ? pwr_pkg::ST_IDLE2 : pwr_pkg::ST_SECOND_IDLE_STATE))
        else $error("halt did not reach idle state");
    chk_deep_gates: assert property (state_q == pwr_pkg::ST_DEEP |-> gate_q == 4'h0 && wdt_cnt_q == 16'h0000)
        else $error("deep sleep clocks or watchdog not stopped");
    chk_pdf_entry: assert property (halt_go & ~wdt_ovf |=> pdf_q && !to_q)
        else $error("entry flags wrong");
    chk_ovf_wake: assert property (wdt_ovf && asleep |=> to_q && evt_q.wdog_rst && state_q == pwr_pkg::ST_RUN)
        else $error("overflow did not wake");
    chk_stale_irq: assert property (asleep && !wake_any |=> $stable(state_q))
        else $error("woke without a wake source");
    chk_hs_select: assert property (##1 hs_sel_q == ($past(mode_q[0]) | ($past(mode_q[7:5]) >= 3'h2)))
        else $error("high-speed select wrong");
    chk_pa_resume: assert property (asleep && pa_wake && !ext_fall && !wdt_ovf && irq_new == '0 |=> evt_q.resume)
        else $error("port wake did not resume");
    chk_ready_low: assert property (osc_stop |=> !ready_q [*2])
        else $error("ready flag not cleared on sleep");
    chk_sleep_gates: assert property (state_q == pwr_pkg::ST_SLEEP2 |-> !gate_q.sys && !gate_q.tbase && gate_q.sub)
        else $error("sleep2 clock gates wrong");
    chk_second_idle_state_gates: assert property (state_q == pwr_pkg::ST_SECOND_IDLE_STATE |-> !gate_q.sys && gate_q.tbase && gate_q.sub)
        else $error("second_idle_state clock gates wrong");
    chk_idle2_gates: assert property (state_q == pwr_pkg::ST_IDLE2 |-> gate_q.sys && gate_q.tbase && gate_q.sub)
        else $error("idle2 clock gates wrong");
    chk_irq_service: assert property (asleep && irq_svc |=> evt_q.irq_svc && state_q == pwr_pkg::ST_RUN)
        else $error("interrupt wake not serviced");
    chk_ext_wake: assert property (ext_fall |=> evt_q.full_rst)
        else $error("external fall gave no full reset");
    chk_wdt_halt_clr: assert property (halt_go |=> wdt_cnt_q == 16'h0000)
        else $error("watchdog not cleared on halt");
    chk_pdf_clear: assert property (wdt_clr_ok && !halt_go |=> !pdf_q)
        else $error("power-down flag not cleared");
    chk_ready_count: assert property ($rose(ready_q) |-> hs_cnt_q == hs_target)
        else $error("ready flag rose at wrong count");
    chk_to_entry: assert property (halt_go && wdt_ovf |=> to_q)
        else $error("overflow lost against halt");
    chk_halt_ignored: assert property (asleep && halt_req && !wake_any |=> $stable(state_q))
        else $error("halt taken in low power");
    chk_one_event: assert property (evt_q.resume |-> !evt_q.irq_svc && !evt_q.full_rst && !evt_q.wdog_rst)
        else $error("resume with another wake event");
    chk_ovf_run: assert property (wdt_ovf && !asleep |=> evt_q.wdog_rst && to_q)
        else $error("overflow in run gave no watchdog reset");
    cov_deep: cover property (halt_go ##1 state_q == pwr_pkg::ST_DEEP);
    cov_idle2: cover property (state_q == pwr_pkg::ST_IDLE2 ##1 state_q == pwr_pkg::ST_RUN);
    cov_irq_svc: cover property (evt_q.irq_svc);
    cov_fast: cover property (run_sub_q ##1 !run_sub_q);
    cov_sleep2_irq: cover property (state_q == pwr_pkg::ST_SLEEP2 ##1 evt_q.irq_svc);
endmodule : halt_power_mode_wakeup_ctrl
`default_nettype wire

// ### tb/pwr_partner.sv
// core and wake-source model facing the power-mode controller
`timescale 1ns/10ps
`default_nettype none
module pwr_partner #(
    parameter int N_PA = 8,
    parameter int N_IRQ = 4
) (
    // clock
    input wire logic pclk,
    // core side
    output logic halt_req,
    output logic wdt_clr,
    output logic [N_IRQ-1:0] irq_req,
    // pins and oscillators
    output logic ext_reset_n,
    output logic [N_PA-1:0] port_a,
    output logic sub_clock,
    output logic hs_osc
);
    logic [2:0] div_q = 3'h0;
    initial begin
        halt_req = 1'b0;
        wdt_clr = 1'b0;
        irq_req = '0;
        ext_reset_n = 1'b1;
        port_a = '1;
    end
    // ************************************************************
    // oscillators
    // ************************************************************
    // both run free: sub-clock at pclk/8, fast oscillator at pclk/4, slow enough for the synchronisers
    always @(posedge pclk) begin
        div_q <= div_q + 3'h1;
    end
    assign sub_clock = div_q[2];
    assign hs_osc = div_q[1];
    // ************************************************************
    // core instructions and wake sources
    // ************************************************************
    task automatic do_halt();
        @(posedge pclk);
        halt_req <= 1'b1;
        @(posedge pclk);
        halt_req <= 1'b0;
    endtask : do_halt
    task automatic clear_wdt();
        @(posedge pclk);
        wdt_clr <= 1'b1;
        @(posedge pclk);
        wdt_clr <= 1'b0;
    endtask : clear_wdt
    task automatic raise_irq(input logic [N_IRQ-1:0] m);
        @(posedge pclk);
        irq_req <= m;
    endtask : raise_irq
    task automatic set_pins(input logic [N_PA-1:0] v);
        @(posedge pclk);
        port_a <= v;
    endtask : set_pins
    task automatic set_ext(input logic v);
        @(posedge pclk);
        ext_reset_n <= v;
    endtask : set_ext
endmodule : pwr_partner
`default_nettype wire

// ### tb/test_halt_power_mode_wakeup_ctrl.sv
// self-checking bench of the power-mode controller
`timescale 1ns/10ps
`default_nettype none
`include "pwr_cfg.svh"
module test_halt_power_mode_wakeup_ctrl;
    logic pclk = 1'b0;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] irq_en;
    logic stack_full;
    logic [31:0] prdata;
    logic pready, pslverr, halt_req, wdt_clr, ext_reset_n, sub_clock, hs_osc;
    logic [3:0] irq_req;
    logic [7:0] port_a;
    logic cpu_halted, use_high_speed, run_from_sub, high_speed_ready_flag, power_down_flag, watchdog_timeout_flag;
    pwr_pkg::clk_gate_t clk_gate;
    pwr_pkg::wake_evt_t wake_evt;
    int mismatches = 0;
    int total_checks = 0;
    int cyc = 0;
    always #5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    halt_power_mode_wakeup_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .halt_req(halt_req), .wdt_clr(wdt_clr), .irq_req(irq_req), .irq_en(irq_en), .stack_full(stack_full),
        .ext_reset_n(ext_reset_n), .port_a(port_a), .sub_clock(sub_clock), .hs_osc(hs_osc),
        .clk_gate(clk_gate), .wake_evt(wake_evt), .cpu_halted(cpu_halted), .use_high_speed(use_high_speed),
        .run_from_sub(run_from_sub), .high_speed_ready_flag(high_speed_ready_flag),
        .power_down_flag(power_down_flag), .watchdog_timeout_flag(watchdog_timeout_flag));
    pwr_partner far (.pclk(pclk), .halt_req(halt_req), .wdt_clr(wdt_clr), .irq_req(irq_req),
        .ext_reset_n(ext_reset_n), .port_a(port_a), .sub_clock(sub_clock), .hs_osc(hs_osc));
    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r, output logic e);
        apb(1'b0, a, 32'h0, r, e);
    endtask : rd
    task automatic wait_wake(input int lim, output logic [3:0] ev);
        ev = 4'h0;
        for (int n = 0; n < lim && ev === 4'h0; n++) begin
            @(posedge pclk);
            ev = wake_evt;
        end
    endtask : wait_wake
    task automatic halt_and_settle();
        far.do_halt();
        for (int n = 0; n < 6 && cpu_halted !== 1'b1; n++) @(posedge pclk);
        #1;
    endtask : halt_and_settle
    task automatic settle();
        @(posedge pclk);
        #1;
    endtask : settle
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset_regs();
        logic [31:0] r;
        logic e;
        chk(use_high_speed, 1'b1);
        rd(`OFF_MODE, r, e);
        chk(r, 32'h01);
        rd(`OFF_WDOG, r, e);
        chk(r, 32'h7A);
        rd(8'h14, r, e);
        chk(r, 32'h0);
        chk(e, 1'b1);
        wr(`OFF_STAT, 32'hFF);
        rd(`OFF_STAT, r, e);
        chk(r, 32'h04);
    endtask : t_reset_regs
    task automatic t_ready();
        for (int n = 0; n < 6000 && high_speed_ready_flag !== 1'b1; n++) @(posedge pclk);
        chk(cyc >= 4105 && cyc <= 4145, 1'b1);
    endtask : t_ready
    task automatic t_clock_select();
        for (int c = 0; c < 8; c++) begin
            wr(`OFF_MODE, {24'h0, 3'(c), 5'h00});
            repeat (2) @(posedge pclk);
            #1;
            chk(use_high_speed, c >= 2);
        end
        wr(`OFF_MODE, 32'h01);
    endtask : t_clock_select
    task automatic t_deep();
        logic [3:0] ev;
        wr(`OFF_WDOG, 32'h0A);
        wr(`OFF_MISC, 32'h0);
        wr(`OFF_WAKE, 32'h01);
        halt_and_settle();
        chk(cpu_halted, 1'b1);
        chk(clk_gate, 4'h0);
        chk({power_down_flag, watchdog_timeout_flag, high_speed_ready_flag}, 3'b100);
        far.set_pins(8'hF7);
        wait_wake(10, ev);
        chk(ev, 4'h0);
        far.set_pins(8'hF6);
        wait_wake(10, ev);
        chk(ev, 4'h1);
        settle();
        chk({cpu_halted, clk_gate}, 5'h0D);
        far.set_pins(8'hFF);
    endtask : t_deep
    task automatic t_sleep2();
        logic [3:0] ev;
        wr(`OFF_MISC, 32'h1);
        wr(`OFF_MODE, 32'h09);
        far.raise_irq(4'h1);
        halt_and_settle();
        chk({cpu_halted, clk_gate.sys, clk_gate.tbase, clk_gate.sub}, 4'b1001);
        wait_wake(20, ev);
        chk(ev, 4'h0);
        far.raise_irq(4'h3);
        wait_wake(10, ev);
        chk(ev, 4'h2);
        settle();
        chk(run_from_sub, 1'b1);
        far.raise_irq(4'h0);
        wr(`OFF_MISC, 32'h0);
    endtask : t_sleep2
    task automatic t_second_idle_state();
        logic [3:0] ev;
        wr(`OFF_MODE, 32'h03);
        stack_full <= 1'b1;
        halt_and_settle();
        chk({cpu_halted, clk_gate.sys, clk_gate.tbase, clk_gate.sub}, 4'b1011);
        far.raise_irq(4'h4);
        wait_wake(10, ev);
        chk(ev, 4'h1);
        far.raise_irq(4'h0);
        stack_full <= 1'b0;
        irq_en <= 4'hB;
        halt_and_settle();
        chk(cpu_halted, 1'b1);
        far.raise_irq(4'h4);
        wait_wake(10, ev);
        chk(ev, 4'h1);
        far.raise_irq(4'h0);
        irq_en <= 4'hF;
    endtask : t_second_idle_state
    task automatic t_idle2();
        logic [3:0] ev;
        // timeout code 000 keeps the overflow at 256 sub-clock ticks, about 2048 cycles
        wr(`OFF_WDOG, 32'h85);
        halt_and_settle();
        chk({cpu_halted, clk_gate.sys, clk_gate.tbase, clk_gate.sub}, 4'b1111);
        wait_wake(1990, ev);
        chk(ev, 4'h0);
        wait_wake(150, ev);
        chk(ev, 4'h4);
        settle();
        chk({watchdog_timeout_flag, power_down_flag}, 2'b11);
        far.clear_wdt();
        settle();
        chk({watchdog_timeout_flag, power_down_flag}, 2'b10);
        wr(`OFF_WDOG, 32'h0A);
    endtask : t_idle2
    task automatic t_ext_reset();
        logic [3:0] ev;
        halt_and_settle();
        chk(cpu_halted, 1'b1);
        far.set_ext(1'b0);
        wait_wake(10, ev);
        chk(ev, 4'h8);
        far.set_ext(1'b1);
        repeat (4) @(posedge pclk);
    endtask : t_ext_reset
    // ************************************************************
    // run control
    // ************************************************************
    task automatic results();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    initial begin
        presetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0000_0000;
        irq_en <= 4'hF;
        stack_full <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_regs();
        t_ready();
        t_clock_select();
        t_deep();
        t_sleep2();
        t_second_idle_state();
        t_idle2();
        t_ext_reset();
        results();
    end
    // the whole sequence needs about 6400 cycles; this leaves ample margin
    initial begin
        #500_000;
        mismatches++;
        results();
    end
endmodule : test_halt_power_mode_wakeup_ctrl
`default_nettype wire
